// ==== common/vbus_pkg.sv ====
// vbus_pkg: constants for both ends and the interface between them.
// assumes both ends run on pclk from one reset, presetn.
//
// Summary of operation
// R1 - session end sets on low vbus
// R2 - session end off when both enables clear
// R3 - single-role link disables session end
// R4 - pulse vbus only after session end
// R5 - session valid readable in status
// R6 - session valid change sends rx cmd
// R7 - session valid enables gate irq only
// R8 - link uses session valid
// R9 - vbus valid off when both enables clear
// R10 - peripheral link disables vbus valid
// R11 - indicator tied high, selection off
// R12 - rx cmd vbus valid via mux
// R13 - peripheral ignores vbus valid
// R14 - discharge follows otg bit 3
// R15 - charge follows otg bit 4
// R16 - link drives external vbus supply
// R17 - comparators synchronised, edges detected
package vbus_pkg;

    // ------------------------------------------------------------
    // link clock
    // ------------------------------------------------------------
    localparam int PCLK_PERIOD_NS = 25;
    localparam int LCLK_PERIOD_NS = 200;
    localparam int LCLK_DIV       = LCLK_PERIOD_NS / PCLK_PERIOD_NS;
    localparam int LCLK_CNT_W     = 3;
    localparam logic [LCLK_CNT_W-1:0] LCLK_LAST     = 3'h7;
    localparam logic [LCLK_CNT_W-1:0] LCLK_FALL_CNT = 3'h3;
    localparam logic [LCLK_CNT_W-1:0] DEV_SAMPLE_CNT = 3'h3;

    // ------------------------------------------------------------
    // transceiver register port
    // ------------------------------------------------------------
    localparam int REG_AW = 2;
    localparam int REG_DW = 8;
    localparam logic [REG_AW-1:0] RA_RISE_EN = 2'h0;
    localparam logic [REG_AW-1:0] RA_FALL_EN = 2'h1;
    localparam logic [REG_AW-1:0] RA_OTG_CTL = 2'h2;
    localparam logic [REG_AW-1:0] RA_IND_CTL = 2'h3;
    localparam logic [REG_DW-1:0] REG_RESET  = 8'h00;

    // status / enable bit positions
    localparam int ST_VBUS_VALID = 1;
    localparam int ST_SESS_VALID = 2;
    localparam int ST_SESS_END   = 3;
    // otg control bits
    localparam int OTG_DISCHARGE = 3;
    localparam int OTG_CHARGE    = 4;
    localparam int OTG_EXT_DRIVE = 5;
    // indicator control bits
    localparam int IND_SELECT = 0;
    localparam int IND_BYPASS = 1;
    localparam int IND_INVERT = 2;
    localparam logic EXT_INDICATOR_LEVEL = 1'b1;

    // rx cmd layout: [3:2] vbus state, [4] interrupt
    localparam int RX_STATE_LSB = 2;
    localparam int RX_INT_BIT   = 4;
    localparam logic [1:0] VS_BELOW_END = 2'h0;
    localparam logic [1:0] VS_END_SV    = 2'h1;
    localparam logic [1:0] VS_SV_VB     = 2'h2;
    localparam logic [1:0] VS_VBUS_OK   = 2'h3;

    // ------------------------------------------------------------
    // link controller apb map
    // ------------------------------------------------------------
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] A_RISE_EN  = 8'h00;
    localparam logic [APB_AW-1:0] A_FALL_EN  = 8'h04;
    localparam logic [APB_AW-1:0] A_OTG_CTL  = 8'h08;
    localparam logic [APB_AW-1:0] A_IND_CTL  = 8'h0c;
    localparam logic [APB_AW-1:0] A_STATUS   = 8'h10;
    localparam logic [APB_AW-1:0] A_INT_STAT = 8'h14;
    localparam logic [APB_AW-1:0] A_INT_MASK = 8'h18;
    localparam logic [APB_AW-1:0] A_ROLE     = 8'h1c;
    localparam int INT_W = 4;
    localparam int EV_RXCMD = 0;
    localparam int EV_SV    = 1;
    localparam int EV_VB    = 2;
    localparam int EV_SE    = 3;

    typedef enum logic [1:0] {ROLE_OTG, ROLE_HOST, ROLE_PERIPH} role_t;

endpackage : vbus_pkg

// ==== common/vbus_link_if.sv ====
// vbus_link_if: wires between transceiver end and link end.
// assumes the transceiver end drives lclk and the link end samples it.
`timescale 1ns/1ps
`default_nettype none
interface vbus_link_if;
    import vbus_pkg::*;
    logic              lclk;
    logic              wr_stb;
    logic [REG_AW-1:0] wr_addr;
    logic [REG_DW-1:0] wr_data;
    logic              rxcmd_valid;
    logic [REG_DW-1:0] rxcmd_data;
    logic [REG_DW-1:0] status;

    modport dev_end (output lclk, rxcmd_valid, rxcmd_data, status,
                     input  wr_stb, wr_addr, wr_data);
    modport link_end (input  lclk, rxcmd_valid, rxcmd_data, status,
                      output wr_stb, wr_addr, wr_data);
endinterface : vbus_link_if
`default_nettype wire

// ==== core/vbus_phy_end.sv ====
// vbus_phy_end: transceiver side vbus monitor, rx cmd source, pulsing.
// assumes comparator inputs are asynchronous and the link samples lclk.
`timescale 1ns/1ps
`default_nettype none
module vbus_phy_end (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // link side
    vbus_link_if.dev_end lnk,
    // analog comparator outputs
    input  wire logic session_end_cmp,
    input  wire logic session_valid_cmp,
    input  wire logic vbus_valid_cmp,
    // pulsing resistor controls
    output logic      vbus_discharge_ctl,
    output logic      vbus_charge_ctl
);
    import vbus_pkg::*;

    // ----------------
    // link clock divider
    // ----------------
    logic [LCLK_CNT_W-1:0] cnt_reg;
    logic                  lclk_reg;
    wire                   div_wrap = (cnt_reg == LCLK_LAST);
    wire                   fall_pt  = (cnt_reg == LCLK_FALL_CNT);
    wire                   samp_pt  = (cnt_reg == DEV_SAMPLE_CNT);

    // counter and clock output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg  <= '0;
            lclk_reg <= 1'b1;
        end else begin
            cnt_reg  <= div_wrap ? '0 : cnt_reg + 1'b1;
            lclk_reg <= div_wrap ? 1'b1 : (fall_pt ? 1'b0 : lclk_reg);
        end
    end

    // ----------------
    // synchronisers
    // ----------------
    localparam int WR_W = 1 + REG_AW + REG_DW;
    logic [WR_W-1:0] wr_s1_reg;
    logic [WR_W-1:0] wr_s2_reg;
    logic [2:0]      cmp_s1_reg;
    logic [2:0]      cmp_s2_reg;

    // two flops on link writes and comparators
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_s1_reg  <= '0;
            wr_s2_reg  <= '0;
            cmp_s1_reg <= '0;
            cmp_s2_reg <= '0;
        end else begin
            wr_s1_reg  <= {lnk.wr_stb, lnk.wr_addr, lnk.wr_data};
            wr_s2_reg  <= wr_s1_reg;
            cmp_s1_reg <= {session_end_cmp, session_valid_cmp,
                           vbus_valid_cmp};          // [R17]
            cmp_s2_reg <= cmp_s1_reg;
        end
    end

    wire              wr_stb_s  = wr_s2_reg[WR_W-1];
    wire [REG_AW-1:0] wr_addr_s = wr_s2_reg[REG_DW +: REG_AW];
    wire [REG_DW-1:0] wr_data_s = wr_s2_reg[REG_DW-1:0];

    // ----------------
    // registers written by the link
    // ----------------
    logic [REG_DW-1:0] rise_en_reg;
    logic [REG_DW-1:0] fall_en_reg;
    logic [REG_DW-1:0] otg_reg;
    logic [REG_DW-1:0] ind_reg;
    wire               wr_take = wr_stb_s & samp_pt;

    // writes taken once per link clock period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_en_reg <= REG_RESET;
            fall_en_reg <= REG_RESET;
            otg_reg     <= REG_RESET;
            ind_reg     <= REG_RESET;              // [R11]
        end else if (wr_take) begin
            if (wr_addr_s == RA_RISE_EN)
                rise_en_reg <= wr_data_s;
            if (wr_addr_s == RA_FALL_EN)
                fall_en_reg <= wr_data_s;
            if (wr_addr_s == RA_OTG_CTL)
                otg_reg <= wr_data_s;
            if (wr_addr_s == RA_IND_CTL)
                ind_reg <= wr_data_s;
        end
    end

    // pulsing resistors follow the otg bits
    assign vbus_discharge_ctl = otg_reg[OTG_DISCHARGE];  // [R14]
    assign vbus_charge_ctl    = otg_reg[OTG_CHARGE];     // [R15]

    // ----------------
    // comparator gating and levels
    // ----------------
    wire se_on = rise_en_reg[ST_SESS_END] | fall_en_reg[ST_SESS_END];
    wire vb_on = rise_en_reg[ST_VBUS_VALID] | fall_en_reg[ST_VBUS_VALID];
    wire se_lvl = cmp_s2_reg[2] & se_on;           // [R1] [R2]
    wire sv_lvl = cmp_s2_reg[1];                   // [R5] [R7]
    wire vb_lvl = cmp_s2_reg[0] & vb_on;           // [R9]

    logic [REG_DW-1:0] lvl;
    // status byte layout
    always_comb begin
        lvl                = '0;
        lvl[ST_SESS_END]   = se_lvl;
        lvl[ST_SESS_VALID] = sv_lvl;
        lvl[ST_VBUS_VALID] = vb_lvl;
    end

    // rx cmd vbus valid selection, indicator held high
    wire ind_term = EXT_INDICATOR_LEVEL ^ ind_reg[IND_INVERT];
    wire ext_vb   = ind_reg[IND_BYPASS] ? ind_term : (vb_lvl & ind_term);
    wire rx_vb    = ind_reg[IND_SELECT] ? ext_vb : vb_lvl;   // [R12]

    // vbus state encoding for rx cmd
    wire [1:0] vstate = rx_vb  ? VS_VBUS_OK :
                        sv_lvl ? VS_SV_VB :
                        se_lvl ? VS_BELOW_END : VS_END_SV;

    // ----------------
    // edge detection and rx cmd scheduling
    // ----------------
    logic [REG_DW-1:0] lvl_prev_reg;
    logic              rx_vb_prev_reg;
    logic              pend_reg;
    logic              int_pend_reg;
    logic              rxv_reg;
    logic [REG_DW-1:0] rxd_reg;
    logic [REG_DW-1:0] status_reg;

    wire [REG_DW-1:0] rise_ev = lvl & ~lvl_prev_reg;             // [R17]
    wire [REG_DW-1:0] fall_ev = ~lvl & lvl_prev_reg;
    wire trig = (|(lvl ^ lvl_prev_reg)) | (rx_vb ^ rx_vb_prev_reg); // [R6]
    wire int_ev = |((rise_ev & rise_en_reg) | (fall_ev & fall_en_reg));
    // a new change in the send cycle stays pending
    wire pend_next     = trig | (pend_reg & ~fall_pt);
    wire int_pend_next = int_ev | (int_pend_reg & ~fall_pt);

    logic [REG_DW-1:0] rx_word;
    // rx cmd byte assembly
    always_comb begin
        rx_word = '0;
        rx_word[RX_STATE_LSB +: 2] = vstate;
        rx_word[RX_INT_BIT]        = int_pend_reg;
    end

    // previous levels and pending flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_prev_reg   <= '0;
            rx_vb_prev_reg <= 1'b0;
            pend_reg       <= 1'b0;
            int_pend_reg   <= 1'b0;
        end else begin
            lvl_prev_reg   <= lvl;
            rx_vb_prev_reg <= rx_vb;
            pend_reg       <= pend_next;
            int_pend_reg   <= int_pend_next;
        end
    end

    // link outputs change with the falling link clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxv_reg    <= 1'b0;
            rxd_reg    <= '0;
            status_reg <= '0;
        end else if (fall_pt) begin
            rxv_reg    <= pend_reg;                 // [R6] [R7]
            rxd_reg    <= pend_reg ? rx_word : rxd_reg;
            status_reg <= lvl;                      // [R5]
        end
    end

    assign lnk.lclk        = lclk_reg;
    assign lnk.rxcmd_valid = rxv_reg;
    assign lnk.rxcmd_data  = rxd_reg;
    assign lnk.status      = status_reg;

endmodule : vbus_phy_end
`default_nettype wire

// ==== core/vbus_link_end.sv ====
// vbus_link_end: link controller with apb registers, drives the transceiver.
// assumes lclk arrives from the transceiver and is sampled on pclk.
`timescale 1ns/1ps
`default_nettype none
module vbus_link_end (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [vbus_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        irq,
    // transceiver side
    vbus_link_if.link_end               lnk,
    // user side
    output logic                        session_present,
    output logic                        vbus_ok,
    output logic                        ext_supply_drive_ctl
);
    import vbus_pkg::*;

    // ------------------------------------------------------------
    // synchronisers and link clock edges
    // ------------------------------------------------------------
    localparam int RX_W = 1 + 2 * REG_DW;
    logic            lclk_s1_reg, lclk_s2_reg, lclk_prev_reg;
    logic [RX_W-1:0] rx_s1_reg, rx_s2_reg;

    // two flops on every transceiver output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lclk_s1_reg   <= 1'b1;   // lclk idles high
            lclk_s2_reg   <= 1'b1;
            lclk_prev_reg <= 1'b1;
            rx_s1_reg     <= '0;
            rx_s2_reg     <= '0;
        end else begin
            lclk_s1_reg   <= lnk.lclk;
            lclk_s2_reg   <= lclk_s1_reg;
            lclk_prev_reg <= lclk_s2_reg;
            rx_s1_reg <= {lnk.rxcmd_valid, lnk.rxcmd_data, lnk.status};
            rx_s2_reg <= rx_s1_reg;
        end
    end

    wire              l_rise  = lclk_s2_reg & ~lclk_prev_reg;
    wire              l_fall  = ~lclk_s2_reg & lclk_prev_reg;
    wire              rxv_s   = rx_s2_reg[RX_W-1];
    wire [REG_DW-1:0] rxd_s   = rx_s2_reg[REG_DW +: REG_DW];
    wire [REG_DW-1:0] dstat_s = rx_s2_reg[REG_DW-1:0];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [REG_DW-1:0] rise_reg, fall_reg, otg_reg, ind_reg;
    logic [INT_W-1:0]  int_stat_reg, int_mask_reg;
    logic [1:0]        role_reg;
    logic [REG_DW-1:0] flags_reg;
    logic [31:0]       prdata_reg;

    wire acc    = psel & penable;
    wire wr     = acc & pwrite;
    wire w_rise = wr & (paddr == A_RISE_EN);
    wire w_fall = wr & (paddr == A_FALL_EN);
    wire w_otg  = wr & (paddr == A_OTG_CTL);
    wire w_ind  = wr & (paddr == A_IND_CTL);
    wire w_stat = wr & (paddr == A_INT_STAT);
    wire w_mask = wr & (paddr == A_INT_MASK);
    wire w_role = wr & (paddr == A_ROLE);
    // offsets are dense and word aligned
    wire hit    = (paddr[1:0] == 2'h0) &
                  (paddr <= A_ROLE);

    // read mux, captured in the setup cycle
    wire [31:0] rmux =
        (paddr == A_RISE_EN)  ? {24'h0, rise_reg} :
        (paddr == A_FALL_EN)  ? {24'h0, fall_reg} :
        (paddr == A_OTG_CTL)  ? {24'h0, otg_reg} :
        (paddr == A_IND_CTL)  ? {24'h0, ind_reg} :
        (paddr == A_STATUS)   ? {16'h0, dstat_s, flags_reg} :
        (paddr == A_INT_STAT) ? {28'h0, int_stat_reg} :
        (paddr == A_INT_MASK) ? {28'h0, int_mask_reg} :
        (paddr == A_ROLE)     ? {30'h0, role_reg} : 32'h0;

    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata  = prdata_reg;

    // ------------------------------------------------------------
    // values forwarded to the transceiver
    // ------------------------------------------------------------
    wire is_host   = (role_reg == ROLE_HOST);
    wire is_periph = (role_reg == ROLE_PERIPH);
    logic [REG_DW-1:0] role_keep;
    // single-role links switch unused comparators off
    always_comb begin
        role_keep                = 8'hff;
        role_keep[ST_SESS_END]   = ~(is_host | is_periph);   // [R3]
        role_keep[ST_VBUS_VALID] = ~is_periph;               // [R10]
    end

    logic pulse_ok_reg;
    // charging is held back until the session has ended
    wire se_seen       = flags_reg[ST_SESS_END];
    wire pulse_ok_next = otg_reg[OTG_CHARGE] & (pulse_ok_reg | se_seen);
    logic [REG_DW-1:0] otg_eff;
    always_comb begin
        otg_eff             = otg_reg;
        otg_eff[OTG_CHARGE] = otg_reg[OTG_CHARGE] & pulse_ok_reg; // [R4]
    end

    // pending register transfers, one per link clock period
    logic [3:0]        dirty_reg;
    logic              wstb_reg;
    logic [REG_AW-1:0] waddr_reg;
    logic [REG_DW-1:0] wdata_reg;
    wire [REG_AW-1:0] pick = dirty_reg[0] ? RA_RISE_EN :
                             dirty_reg[1] ? RA_FALL_EN :
                             dirty_reg[2] ? RA_OTG_CTL : RA_IND_CTL;
    wire [REG_DW-1:0] pick_data =
        (pick == RA_RISE_EN) ? (rise_reg & role_keep) :
        (pick == RA_FALL_EN) ? (fall_reg & role_keep) :
        (pick == RA_OTG_CTL) ? otg_eff : ind_reg;
    wire       send    = l_fall & (|dirty_reg);
    wire [3:0] clr     = send ? (4'h1 << pick) : 4'h0;
    wire       pok_chg = pulse_ok_next ^ pulse_ok_reg;
    wire [3:0] set     = {w_ind, w_otg | pok_chg,
                          w_fall | w_role, w_rise | w_role};

    // ------------------------------------------------------------
    // rx cmd decode and events
    // ------------------------------------------------------------
    wire [1:0] vs = rxd_s[RX_STATE_LSB +: 2];
    logic [REG_DW-1:0] flags_new;
    always_comb begin
        flags_new                = '0;
        flags_new[ST_VBUS_VALID] = (vs == VS_VBUS_OK);
        flags_new[ST_SESS_VALID] = (vs == VS_SV_VB) | (vs == VS_VBUS_OK);
        flags_new[ST_SESS_END]   = (vs == VS_BELOW_END);
    end
    wire              rx_take = l_rise & rxv_s;
    wire [REG_DW-1:0] fdiff   = flags_new ^ flags_reg;
    wire [INT_W-1:0]  ev = rx_take ? {fdiff[ST_SESS_END],
                                      fdiff[ST_VBUS_VALID],
                                      fdiff[ST_SESS_VALID], 1'b1} : '0;
    wire [INT_W-1:0]  w1c = w_stat ? pwdata[INT_W-1:0] : '0;

    // apb registers, events win over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_reg     <= REG_RESET;
            fall_reg     <= REG_RESET;
            otg_reg      <= REG_RESET;
            ind_reg      <= REG_RESET;
            role_reg     <= ROLE_OTG;
            int_mask_reg <= '0;
            int_stat_reg <= '0;
            flags_reg    <= '0;
            prdata_reg   <= '0;
            pulse_ok_reg <= 1'b0;
        end else begin
            if (w_rise) rise_reg <= pwdata[REG_DW-1:0];
            if (w_fall) fall_reg <= pwdata[REG_DW-1:0];
            if (w_otg)  otg_reg  <= pwdata[REG_DW-1:0];
            if (w_ind)  ind_reg  <= pwdata[REG_DW-1:0];
            if (w_role) role_reg <= pwdata[1:0];
            if (w_mask) int_mask_reg <= pwdata[INT_W-1:0];
            int_stat_reg <= ev | (int_stat_reg & ~w1c);
            if (rx_take) flags_reg <= flags_new;
            if (psel & ~penable) prdata_reg <= rmux;
            pulse_ok_reg <= pulse_ok_next;
        end
    end

    // transfers toward the transceiver change on the falling link clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dirty_reg <= '0;
            wstb_reg  <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
        end else begin
            dirty_reg <= set | (dirty_reg & ~clr);
            if (l_fall) begin
                wstb_reg  <= |dirty_reg;
                waddr_reg <= pick;
                wdata_reg <= pick_data;
            end
        end
    end

    assign lnk.wr_stb  = wstb_reg;
    assign lnk.wr_addr = waddr_reg;
    assign lnk.wr_data = wdata_reg;

    assign irq = |(int_stat_reg & int_mask_reg);
    assign session_present = flags_reg[ST_SESS_VALID];          // [R8] [R13]
    assign vbus_ok = flags_reg[ST_VBUS_VALID] & ~is_periph;     // [R13]
    assign ext_supply_drive_ctl = otg_reg[OTG_EXT_DRIVE];       // [R16]

endmodule : vbus_link_end
`default_nettype wire

// ==== testbench/vbus_link_monitor.sv ====
// vbus_link_monitor: assertions on the wires between the two ends.
// assumes one pclk domain and presetn active low, asynchronous.
`timescale 1ns/1ps
`default_nettype none
module vbus_link_monitor (
    // clock and reset
    input wire logic                         pclk,
    input wire logic                         presetn,
    // link wires
    input wire logic                         lclk,
    input wire logic                         wr_stb,
    input wire logic [vbus_pkg::REG_AW-1:0]  wr_addr,
    input wire logic [vbus_pkg::REG_DW-1:0]  wr_data,
    input wire logic                         rxcmd_valid,
    input wire logic [vbus_pkg::REG_DW-1:0]  rxcmd_data,
    input wire logic [vbus_pkg::REG_DW-1:0]  status
);
    import vbus_pkg::*;
    logic [REG_DW-1:0] rise_reg, fall_reg, ind_reg;
    logic [4:0]        quiet_reg;
    // enable shadows and age since the last forwarded write
    wire se_off  = !(rise_reg[ST_SESS_END] | fall_reg[ST_SESS_END]);
    wire vb_off  = !(rise_reg[ST_VBUS_VALID] | fall_reg[ST_VBUS_VALID]);
    wire settled = (quiet_reg == 5'h1f);
    // ----------------
    // shadow of forwarded registers
    // ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_reg  <= '0;
            fall_reg  <= '0;
            ind_reg   <= '0;
            quiet_reg <= '0;
        end else if (wr_stb) begin
            quiet_reg <= '0;
            if (wr_addr == RA_RISE_EN) rise_reg <= wr_data;
            if (wr_addr == RA_FALL_EN) fall_reg <= wr_data;
            if (wr_addr == RA_IND_CTL) ind_reg <= wr_data;
        end else if (!settled) begin
            quiet_reg <= quiet_reg + 5'h1;
        end
    end
    // ----------------
    // assertions
    // ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence high_phase_s; lclk [*4] ##1 !lclk; endsequence
    sequence low_phase_s; !lclk [*4] ##1 lclk; endsequence
    lclk_high_a: assert property ($rose(lclk) |-> high_phase_s)
        else $error("lclk high phase");
    lclk_low_a: assert property ($fell(lclk) |-> low_phase_s)
        else $error("lclk low phase");
    rx_hold_a: assert property ($rose(rxcmd_valid) |-> rxcmd_valid [*8])
        else $error("rx cmd too short");
    rx_data_a: assert property
        ($rose(rxcmd_valid) |=> $stable(rxcmd_data) [*7])
        else $error("rx cmd data moved");
    rx_launch_a: assert property ($rose(rxcmd_valid) |-> $fell(lclk))
        else $error("rx cmd off lclk fall");
    sv_rxcmd_a: assert property ($changed(status[ST_SESS_VALID]) |->
        ##[0:16] (rxcmd_valid &&
        rxcmd_data[RX_STATE_LSB+1] == status[ST_SESS_VALID]))
        else $error("no rx cmd for sv change");
    se_off_a: assert property (settled && se_off |-> !status[ST_SESS_END])
        else $error("session end while off");
    vb_off_a: assert property (settled && vb_off |-> !status[ST_VBUS_VALID])
        else $error("vbus valid while off");
    ind_zero_a: assert property (settled && ind_reg[IND_SELECT] &&
        ind_reg[IND_INVERT] && rxcmd_valid |->
        rxcmd_data[RX_STATE_LSB+:2] != VS_VBUS_OK)
        else $error("forced low vbus sent high");
    wr_hold_a: assert property ($rose(wr_stb) |-> !lclk ##1
        ($stable(wr_addr) && $stable(wr_data)) [*7])
        else $error("write not held");
endmodule : vbus_link_monitor
`default_nettype wire

// ==== testbench/otg_vbus_monitor_control_test.sv ====
// otg_vbus_monitor_control_test: both ends joined, driven over apb.
// assumes package, interface and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module otg_vbus_monitor_control_test;
    import vbus_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_val;
    logic        pready, pslverr, irq, sess_p, vbus_ok, ext_drv, dis, chg;
    logic        se_c = 0, sv_c = 0, vb_c = 0, err_seen, e;
    int          num_errors = 0, n_checks = 0, cycles = 0;
    vbus_link_if lnk ();
    vbus_phy_end vbus_phy_end_inst (.pclk(pclk), .presetn(presetn),
        .lnk(lnk), .session_end_cmp(se_c), .session_valid_cmp(sv_c),
        .vbus_valid_cmp(vb_c), .vbus_discharge_ctl(dis),
        .vbus_charge_ctl(chg));
    vbus_link_end vbus_link_end_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .lnk(lnk), .session_present(sess_p),
        .vbus_ok(vbus_ok), .ext_supply_drive_ctl(ext_drv));
    vbus_link_monitor vbus_link_monitor_inst (.pclk(pclk),
        .presetn(presetn), .lclk(lnk.lclk), .wr_stb(lnk.wr_stb),
        .wr_addr(lnk.wr_addr), .wr_data(lnk.wr_data),
        .rxcmd_valid(lnk.rxcmd_valid), .rxcmd_data(lnk.rxcmd_data),
        .status(lnk.status));
    // 40 mhz clock
    always #12.5 pclk = ~pclk;
    // cycle ceiling against hangs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ----------------
    // apb master and checks
    // ----------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd_val   = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] x);
        apb(1'b0, a, '0);
        chk($sformatf("reg %h", a), x, rd_val & m);
    endtask : rdm
    // time for forwarding and the rx cmd back
    task automatic settle();
        repeat (48) @(posedge pclk);
    endtask : settle
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict
    // ----------------
    // main sequence
    // ----------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) rdm(8'(i * 4), '1, '0);
        apb(1'b0, 8'h20, '0);
        chk("unmapped error", 32'h1, 32'(err_seen));
        se_c <= 1'b1;
        settle();
        rdm(A_STATUS, 32'h800, 32'h0);
        apb(1'b1, A_RISE_EN, 32'h8);
        settle();
        rdm(A_STATUS, 32'h800, 32'h800);
        apb(1'b1, A_OTG_CTL, 32'h10);
        settle();
        chk("charge", 32'h1, 32'(chg));
        apb(1'b1, A_OTG_CTL, 32'h28);
        settle();
        chk("discharge", 32'h2, {30'h0, dis, chg});
        chk("ext drive", 32'h1, 32'(ext_drv));
        apb(1'b1, A_OTG_CTL, 32'h0);
        apb(1'b1, A_RISE_EN, 32'h0);
        apb(1'b1, A_INT_MASK, 32'h1);
        settle();
        apb(1'b1, A_INT_STAT, 32'hf);
        settle();
        chk("pins idle", 32'h0, {29'h0, irq, dis, chg});
        sv_c <= 1'b1;
        settle();
        rdm(A_STATUS, 32'h400, 32'h400);
        chk("session present", 32'h1, 32'(sess_p));
        chk("irq raised", 32'h1, 32'(irq));
        rdm(A_INT_STAT, 32'h1, 32'h1);
        apb(1'b1, A_INT_STAT, 32'h1);
        settle();
        rdm(A_INT_STAT, 32'h1, 32'h0);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b1, A_INT_MASK, 32'h0);
        sv_c <= 1'b0;
        settle();
        chk("masked irq", 32'h0, {31'h0, irq | sess_p});
        sv_c <= 1'b1;
        vb_c <= 1'b1;
        settle();
        rdm(A_STATUS, 32'h200, 32'h0);
        apb(1'b1, A_FALL_EN, 32'ha);
        settle();
        rdm(A_STATUS, 32'ha00, 32'ha00);
        for (int k = 0; k < 16; k++) begin
            vb_c <= k[3];
            apb(1'b1, A_IND_CTL, {29'h0, k[2:0]});
            settle();
            e = k[0] ? (k[1] ? !k[2] : k[3] & !k[2]) : k[3];
            chk("indicator mux", 32'(e), 32'(vbus_ok));
        end
        apb(1'b1, A_IND_CTL, 32'h0);
        apb(1'b1, A_ROLE, 32'h1);
        settle();
        rdm(A_STATUS, 32'ha00, 32'h200);
        apb(1'b1, A_ROLE, 32'h2);
        settle();
        chk("periph vbus", 32'h0, 32'(vbus_ok));
        rdm(A_STATUS, 32'ha00, 32'h0);
        give_verdict();
    end
endmodule : otg_vbus_monitor_control_test
`default_nettype wire
